// [rtl/ddrh_ctrl.sv]
// ddr3 host: command spacing scheduler and data strobe framing
`timescale 1ns/10ps
`default_nettype none
module ddrh_ctrl
  import ddrh_pkg::*;
#(
  parameter int GRADE = 0, // 0: 1600, 1: 1866, 2: 2133
  parameter int RL = RL_DEF,
  parameter int WL = WL_DEF,
  parameter int BL = BL_DEF,
  parameter int WR_NCK = WR_NCK_DEF,
  parameter int RP_PS = RP_PS_DEF,
  parameter int DQ_W = 8
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [2:0] cmd_ba,
  input wire logic [15:0] cmd_addr,
  input wire logic [BL*DQ_W-1:0] cmd_wdata,
  output logic rd_valid,
  output logic rd_err,
  output logic [BL*DQ_W-1:0] rd_data,
  output logic rd_window,
  output logic ddr_ck,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output logic [2:0] ddr_ba,
  output logic [15:0] ddr_addr,
  output logic dqs_o,
  output logic dqs_oe_n,
  input wire logic dqs_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_n,
  input wire logic [DQ_W-1:0] dq_i
);
  // ------------------------------------------------------------
  // derived counts
  // ------------------------------------------------------------
  localparam int DIVW = $clog2(CK_DIV);
  localparam int BW = $clog2(BL);
  localparam int RRD_NS = ps2clk((GRADE == 0) ? RRD_PS_SLOW : RRD_PS_FAST);
  localparam int RRD_CLK = (RRD_NS > nck2clk(RRD_NCK)) ? RRD_NS
                                                       : nck2clk(RRD_NCK);
  localparam int FAW_CLK = ps2clk((GRADE == 0) ? FAW_PS_1600 :
                                  (GRADE == 1) ? FAW_PS_1866 : FAW_PS_2133);
  // recovery runs from the end of write data, so latency and burst count
  localparam int DAL_CLK = nck2clk(WL + BL / 2 + WR_NCK
                                   + (RP_PS + CK_PS - 1) / CK_PS);
  localparam int DATA_AT = CK_LAG + WL * CK_DIV;
  localparam int PRE_AT = DATA_AT - CK_DIV;
  localparam int POST_AT = DATA_AT + BL * HALF_CK;
  localparam int END_AT = POST_AT + HALF_CK;
  localparam int RD_BEG = CK_LAG + (RL - 1) * CK_DIV + SYNC_STAGES;
  localparam int RD_END = CK_LAG + (RL + BL / 2) * CK_DIV + SYNC_STAGES;

  // ------------------------------------------------------------
  // memory clock divider and issue slot
  // ------------------------------------------------------------
  logic [DIVW-1:0] div_q;
  logic phase_ok;

  // a command may only launch just before the memory clock falls
  assign phase_ok = (div_q == DIVW'(CK_DIV - 1));
  assign ddr_ck = div_q[DIVW-1];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      div_q <= '0;
    else
      div_q <= div_q + DIVW'(1);
  end

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic iss;
  logic iss_mrs;
  logic iss_mpr;
  logic iss_act;
  logic iss_rd;
  logic iss_wr;
  logic iss_pre;
  logic auto_pre;
  logic [3:0] pin_sel;

  assign iss = cmd_valid && cmd_ready;
  assign iss_mrs = iss && (cmd_op == OP_MRS);
  assign iss_mpr = iss && (cmd_op == OP_MPR);
  assign iss_act = iss && (cmd_op == OP_ACT);
  assign iss_rd = iss && (cmd_op == OP_RD);
  assign iss_wr = iss && (cmd_op == OP_WR);
  assign iss_pre = iss && (cmd_op == OP_PRE);
  assign auto_pre = cmd_addr[AP_BIT];
  assign pin_sel = (cmd_op == OP_MRS || cmd_op == OP_MPR) ? PIN_MRS :
                   (cmd_op == OP_ACT) ? PIN_ACT :
                   (cmd_op == OP_RD) ? PIN_RD :
                   (cmd_op == OP_WR) ? PIN_WR :
                   (cmd_op == OP_PRE) ? PIN_PRE : PIN_NOP;

  // ------------------------------------------------------------
  // spacing timers, global and per bank
  // ------------------------------------------------------------
  logic mrd_done;
  logic mod_done;
  logic mpr_done;
  logic ccd_done;
  logic rrd_done;
  logic wtr_done;
  logic wr_end;
  logic [NBANK-1:0] rtp_done;
  logic [NBANK-1:0] dal_done;

  // mode register spacing
  ddrh_timer #(.W(TW)) u_mrd (.clk(clk), .rst_n(rst_n),
    .load(iss_mrs || iss_mpr), .value(TW'(MRD_CLK)), .done(mrd_done));
  // settle time before ordinary commands
  ddrh_timer #(.W(TW)) u_mod (.clk(clk), .rst_n(rst_n),
    .load(iss_mrs || iss_mpr), .value(TW'(MOD_CLK)), .done(mod_done));
  // register readout exit clock plus one silent memory clock
  ddrh_timer #(.W(TW)) u_mpr (.clk(clk), .rst_n(rst_n),
    .load(iss_mpr), .value(TW'(MPRR_CLK + CK_DIV)), .done(mpr_done));
  // column to column spacing
  ddrh_timer #(.W(TW)) u_ccd (.clk(clk), .rst_n(rst_n),
    .load(iss_rd || iss_wr), .value(TW'(CCD_CLK)), .done(ccd_done));
  // activate to activate spacing
  ddrh_timer #(.W(TW)) u_rrd (.clk(clk), .rst_n(rst_n),
    .load(iss_act), .value(TW'(RRD_CLK)), .done(rrd_done));
  // end of write data to read
  ddrh_timer #(.W(TW)) u_wtr (.clk(clk), .rst_n(rst_n),
    .load(wr_end), .value(TW'(WTR_CLK)), .done(wtr_done));

  // per bank read-to-precharge and auto precharge reopen timers
  for (genvar b = 0; b < NBANK; b++)
  begin : g_bank
    ddrh_timer #(.W(TW)) u_rtp (.clk(clk), .rst_n(rst_n),
      .load(iss_rd && (cmd_ba == 3'(b))), .value(TW'(RTP_CLK)),
      .done(rtp_done[b]));
    ddrh_timer #(.W(TW)) u_dal (.clk(clk), .rst_n(rst_n),
      .load(iss_wr && auto_pre && (cmd_ba == 3'(b))),
      .value(TW'(DAL_CLK)), .done(dal_done[b]));
  end

  // ------------------------------------------------------------
  // rolling four activate window
  // ------------------------------------------------------------
  logic [TW-1:0] faw_q [4];
  logic faw_ok;

  // fifth activate waits until the oldest of four has aged out
  assign faw_ok = (faw_q[3] == '0);

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!rst_n)
        faw_q[i] <= '0;
      else if (iss_act)
        faw_q[i] <= (i == 0) ? TW'(FAW_CLK - 1) :
                    (faw_q[(i == 0) ? 0 : i-1] != '0) ?
                    faw_q[(i == 0) ? 0 : i-1] - TW'(1) : '0;
      else if (faw_q[i] != '0)
        faw_q[i] <= faw_q[i] - TW'(1);
    end
  end

  // ------------------------------------------------------------
  // admission
  // ------------------------------------------------------------
  logic wr_busy;
  logic rd_busy;
  logic op_ok;
  logic base_ok;

  assign base_ok = mod_done && mpr_done;
  assign op_ok = (cmd_op == OP_NOP) ? 1'b1 :
    (cmd_op == OP_MRS || cmd_op == OP_MPR) ? (mrd_done && mpr_done) :
    (cmd_op == OP_ACT) ? (base_ok && rrd_done && faw_ok &&
                          dal_done[cmd_ba]) :
    (cmd_op == OP_RD) ? (base_ok && ccd_done && wtr_done &&
                         !wr_busy && !rd_busy) :
    (cmd_op == OP_WR) ? (base_ok && ccd_done && !wr_busy && !rd_busy) :
    (cmd_op == OP_PRE) ? (base_ok && rtp_done[cmd_ba]) : 1'b0;
  assign cmd_ready = phase_ok && op_ok;

  // ------------------------------------------------------------
  // command pins, held for one memory clock
  // ------------------------------------------------------------
  logic [3:0] pins_q;
  logic [2:0] ba_q;
  logic [15:0] addr_q;

  assign {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} = pins_q;
  assign ddr_ba = ba_q;
  assign ddr_addr = addr_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins_q <= PIN_DES;
      ba_q <= '0;
      addr_q <= '0;
    end
    else if (phase_ok)
    begin
      pins_q <= iss ? pin_sel : PIN_NOP;
      ba_q <= iss ? cmd_ba : ba_q;
      addr_q <= iss ? cmd_addr : addr_q;
    end
  end

  // ------------------------------------------------------------
  // write strobe and data framing
  // ------------------------------------------------------------
  ddrh_wph_t wph_q;
  ddrh_wph_t wph_d;
  logic [TW-1:0] wcnt_q;
  logic [TW-1:0] wcnt_d;
  logic [TW-1:0] woff;
  logic [BW-1:0] beat;
  logic [BL*DQ_W-1:0] wbuf_q;
  logic drive_d;
  logic dqs_d;

  assign wr_busy = (wph_q != W_IDLE);
  assign wcnt_d = iss_wr ? TW'(1) : wr_busy ? wcnt_q + TW'(1) : '0;
  // phase follows the cycle count since the write launched
  assign wph_d = (wcnt_d == '0) ? W_IDLE :
                 (wcnt_d < TW'(PRE_AT)) ? W_LAT :
                 (wcnt_d < TW'(DATA_AT)) ? W_PRE :
                 (wcnt_d < TW'(POST_AT)) ? W_DATA :
                 (wcnt_d < TW'(END_AT)) ? W_POST : W_IDLE;
  assign wr_end = (wph_q == W_DATA) && (wph_d == W_POST);
  assign woff = wcnt_d - TW'(DATA_AT);
  assign beat = BW'(woff / TW'(HALF_CK));

  // strobe low through preamble and postamble, toggling per beat
  always_comb
  begin
    unique case (wph_d)
      W_PRE: {drive_d, dqs_d} = 2'b10;
      W_DATA: {drive_d, dqs_d} = {1'b1, ~beat[0]};
      W_POST: {drive_d, dqs_d} = 2'b10;
      W_IDLE, W_LAT: {drive_d, dqs_d} = 2'b00;
      default: {drive_d, dqs_d} = 2'b00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wph_q <= W_IDLE;
      wcnt_q <= '0;
      wbuf_q <= '0;
      dqs_o <= 1'b0;
      dqs_oe_n <= 1'b1;
      dq_o <= '0;
      dq_oe_n <= 1'b1;
    end
    else
    begin
      wph_q <= wph_d;
      wcnt_q <= wcnt_d;
      wbuf_q <= iss_wr ? cmd_wdata : wbuf_q;
      dqs_o <= dqs_d;
      dqs_oe_n <= !drive_d;
      dq_o <= (wph_d == W_DATA) ? wbuf_q[beat*DQ_W +: DQ_W] : '0;
      dq_oe_n <= (wph_d != W_DATA);
    end
  end

  // ------------------------------------------------------------
  // read strobe window and capture
  // ------------------------------------------------------------
  logic [TW-1:0] rcnt_q;
  logic [TW-1:0] rcnt_d;
  logic rwin_d;
  logic [2:0] dqs_s;
  logic [DQ_W-1:0] dq_s1;
  logic [DQ_W-1:0] dq_s2;
  logic edge_q;
  logic [BW:0] ecnt_q;
  logic [BW:0] ecnt_d;
  logic [BL*DQ_W-1:0] rbuf_q;
  logic [BL*DQ_W-1:0] rbuf_d;
  logic rd_done;

  assign rd_busy = (rcnt_q != '0);
  assign rcnt_d = iss_rd ? TW'(1) :
                  (rd_busy && rcnt_q < TW'(RD_END)) ? rcnt_q + TW'(1) : '0;
  // window spans strobe drive from rl-1 to release at rl+bl/2
  assign rwin_d = (rcnt_d >= TW'(RD_BEG)) && (rcnt_d < TW'(RD_END));
  assign ecnt_d = !rd_window ? '0 :
                  (dqs_s[1] ^ dqs_s[2]) ? ecnt_q + (BW+1)'(1) : ecnt_q;
  assign rd_done = rd_window && !rwin_d;
  // sample one cycle after each strobe edge, mid beat; the last beat
  // can land in the very cycle the burst closes, so hand over rbuf_d
  assign rbuf_d = edge_q ? {dq_s2, rbuf_q[BL*DQ_W-1:DQ_W]} : rbuf_q;

  // two stage synchronisers on the device driven pins
  always_ff @(posedge clk)
  begin
    dqs_s <= {dqs_s[1:0], dqs_i};
    dq_s1 <= dq_i;
    dq_s2 <= dq_s1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rcnt_q <= '0;
      rd_window <= 1'b0;
      edge_q <= 1'b0;
      ecnt_q <= '0;
      rbuf_q <= '0;
      rd_valid <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      rcnt_q <= rcnt_d;
      rd_window <= rwin_d;
      edge_q <= rd_window && (dqs_s[1] ^ dqs_s[2]);
      ecnt_q <= ecnt_d;
      rbuf_q <= rbuf_d;
      rd_valid <= rd_done;
      // a burst missing edges means preamble or postamble went wrong
      rd_err <= rd_done && (ecnt_d != (BW+1)'(BL));
      rd_data <= rd_done ? rbuf_d : rd_data;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [7:0] since_mrs_q;
  logic [7:0] since_rd_q;
  logic [7:0] since_wr_q;
  logic [7:0] since_act_q;
  logic [7:0] since_wend_q;
  logic [2:0] rd_ba_q;

  function automatic logic [7:0] sat(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      since_mrs_q <= 8'hFF;
      since_rd_q <= 8'hFF;
      since_wr_q <= 8'hFF;
      since_act_q <= 8'hFF;
      since_wend_q <= 8'hFF;
      rd_ba_q <= '0;
    end
    else
    begin
      since_mrs_q <= (iss_mrs || iss_mpr) ? 8'h00 : sat(since_mrs_q);
      since_rd_q <= iss_rd ? 8'h00 : sat(since_rd_q);
      since_wr_q <= iss_wr ? 8'h00 : sat(since_wr_q);
      since_act_q <= iss_act ? 8'h00 : sat(since_act_q);
      since_wend_q <= wr_end ? 8'h00 : sat(since_wend_q);
      rd_ba_q <= iss_rd ? cmd_ba : rd_ba_q;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wpre;
    (!dqs_oe_n && !dqs_o) [*4];
  endsequence
  sequence s_wpost;
    (!dqs_oe_n && !dqs_o) [*2] ##1 dqs_oe_n;
  endsequence

  a_mrs_spacing: assert property ((iss_mrs || iss_mpr) |->
    int'(since_mrs_q) + 1 >= MRD_CLK) else $error("mode commands too close");
  a_mod_settle: assert property ((iss_act || iss_rd || iss_wr || iss_pre)
    |-> int'(since_mrs_q) + 1 >= MOD_CLK) else $error("mode settle broken");
  a_rd_ccd: assert property (iss_rd |->
    int'(since_rd_q) + 1 >= CCD_CLK) else $error("read to read too close");
  a_wr_ccd: assert property (iss_wr |->
    int'(since_wr_q) + 1 >= CCD_CLK) else $error("write to write too close");
  a_rtp_gap: assert property ((iss_pre && (cmd_ba == rd_ba_q)) |->
    int'(since_rd_q) + 1 >= RTP_CLK) else $error("precharge after read early");
  a_wtr_gap: assert property (iss_rd |->
    int'(since_wend_q) + 1 >= WTR_CLK) else $error("read after write early");
  a_dal_reopen: assert property ((iss_wr && auto_pre) |=>
    !dal_done[$past(cmd_ba)]) else $error("auto precharge bank reopened");
  a_mpr_recover: assert property (iss_mpr |=> !iss [*7])
    else $error("command right after register readout");
  a_rrd_gap: assert property (iss_act |->
    int'(since_act_q) + 1 >= RRD_CLK) else $error("activates too close");
  a_faw_limit: assert property (iss_act |-> faw_ok)
    else $error("fifth activate inside window");
  a_wpre_frame: assert property ($fell(dqs_oe_n) |-> s_wpre ##1 dqs_o)
    else $error("write preamble malformed");
  a_wpost_frame: assert property (wr_end |=> s_wpost)
    else $error("write postamble malformed");
  a_rd_window: assert property ($rose(rd_window) |->
    ##19 rd_window ##1 !rd_window) else $error("read window length wrong");
endmodule // ddrh_ctrl
`default_nettype wire

// [rtl/ddrh_pkg.sv]
// ddr3 host timing constants, command codes and write phases
package ddrh_pkg;
  // ------------------------------------------------------------
  // clocking
  // ------------------------------------------------------------
  localparam int CLK_PS = 20000; // 50 mhz system clock
  localparam int CK_DIV = 4; // memory clock is clk divided by this
  localparam int CK_PS = CLK_PS * CK_DIV;
  localparam int HALF_CK = CK_DIV / 2; // clk cycles per data beat
  localparam int CK_LAG = CK_DIV - 1; // issue to memory clock rise
  localparam int SYNC_STAGES = 2;
  localparam int TW = 8; // width of every timer

  // round a time in ps up to whole clk cycles, never below one
  function automatic int ps2clk(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int nck2clk(input int n);
    return n * CK_DIV;
  endfunction

  // ------------------------------------------------------------
  // spacing figures
  // ------------------------------------------------------------
  localparam int MRD_NCK = 4;
  localparam int MOD_PS = 15000;
  localparam int CCD_NCK = 4;
  localparam int RTP_PS = 7500;
  localparam int WTR_PS = 7500;
  localparam int WR_PS = 15000;
  localparam int MPRR_NCK = 1;
  localparam int RRD_NCK = 4;
  localparam int RRD_PS_SLOW = 6000;
  localparam int RRD_PS_FAST = 5000;
  localparam int FAW_PS_1600 = 30000;
  localparam int FAW_PS_1866 = 27000;
  localparam int FAW_PS_2133 = 25000;
  localparam int RP_PS_DEF = 13750; // precharge time, bin dependent
  localparam int RL_DEF = 6;
  localparam int WL_DEF = 5;
  localparam int BL_DEF = 8;
  localparam int NBANK = 8;
  localparam int AP_BIT = 10;

  localparam int MRD_CLK = nck2clk(MRD_NCK);
  localparam int MOD_CLK = ps2clk(MOD_PS);
  localparam int CCD_CLK = nck2clk(CCD_NCK);
  localparam int RTP_CLK = ps2clk(RTP_PS);
  localparam int WTR_CLK = ps2clk(WTR_PS);
  localparam int MPRR_CLK = nck2clk(MPRR_NCK);
  localparam int WR_NCK_DEF = (WR_PS + CK_PS - 1) / CK_PS;

  // ------------------------------------------------------------
  // user operations and pin codes {cs_n, ras_n, cas_n, we_n}
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_MRS = 3'h1,
    OP_ACT = 3'h2,
    OP_RD = 3'h3,
    OP_WR = 3'h4,
    OP_PRE = 3'h5,
    OP_MPR = 3'h6
  } ddrh_op_t;

  localparam logic [3:0] PIN_DES = 4'hF;
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_MRS = 4'h0;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_RD = 4'h5;
  localparam logic [3:0] PIN_WR = 4'h4;
  localparam logic [3:0] PIN_PRE = 4'h2;

  // write strobe phases, gray along the path
  typedef enum logic [2:0] {
    W_IDLE = 3'h0,
    W_LAT = 3'h1,
    W_PRE = 3'h3,
    W_DATA = 3'h2,
    W_POST = 3'h6
  } ddrh_wph_t;
endpackage

// [rtl/ddrh_timer.sv]
// reloadable down counter that flags when a spacing has elapsed
`timescale 1ns/10ps
`default_nettype none
module ddrh_timer #(
  parameter int W = 8
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // load n makes done rise exactly n cycles after the load cycle
  assign cnt_d = load ? (value - W'(1)) :
                 (cnt_q != '0) ? (cnt_q - W'(1)) : cnt_q;
  assign done = (cnt_q == '0);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule // ddrh_timer
`default_nettype wire

// [verif/ddrh_dev.sv]
// device side model: checks command spacing, answers reads
`timescale 1ns/10ps
`default_nettype none
module ddrh_dev
  import ddrh_pkg::*;
(
  input wire logic clk,
  input wire logic ddr_ck,
  input wire logic [3:0] pins,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  input wire logic dqs_o,
  input wire logic dqs_oe_n,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe_n,
  output logic dev_dqs,
  output logic dev_oe,
  output logic [7:0] dev_dq,
  output logic [63:0] wr_seen,
  output int viol
);
  localparam int DAL = WL_DEF + BL_DEF / 2 + WR_NCK_DEF
    + (RP_PS_DEF + CK_PS - 1) / CK_PS;
  real tck = CK_PS / 1000.0;
  real t_mrs = -1.0e6;
  real t_wend = -1.0e6;
  real t_on = 0.0;
  real t_last = 0.0;
  real t_act[4] = '{default: -1.0e6};
  real t_rd[8] = '{default: -1.0e6};
  int n = 0;
  int n_mrs = -99;
  int n_mpr = -99;
  int n_col = -99;
  int n_act = -99;
  int nb = 0;
  int ok_act[8] = '{default: 0};
  logic drv_q = 1'b0;
  logic s_q = 1'b0;

  task automatic bad(input int k);
    viol++;
    $display("device model: timing breach kind %0d at %0t", k, $time);
  endtask

  // read burst: preamble low, one toggle per beat, then release
  task automatic burst(input logic [7:0] col);
    fork
    begin
      repeat (RL_DEF - 1) @(posedge ddr_ck);
      // move off the sampling edge of clk
      @(negedge clk);
      dev_oe = 1'b1;
      dev_dqs = 1'b0;
      #(tck);
      for (int i = 0; i < BL_DEF; i++)
      begin
        dev_dqs = ~dev_dqs;
        dev_dq = col + 8'(i * 17);
        #(tck / 2.0);
      end
      dev_oe = 1'b0;
      dev_dq = ~dev_dq;
    end
    join_none
  endtask

  initial
  begin
    dev_dqs = 1'b0;
    dev_oe = 1'b0;
    dev_dq = 8'h00;
    wr_seen = 64'h0;
    viol = 0;
  end

  // ----
  // command spacing seen at each memory clock rise
  // ----
  always @(posedge ddr_ck)
  begin
    n = n + 1;
    if (pins != PIN_DES && pins != PIN_NOP)
    begin
      if (pins != PIN_MRS && $realtime - t_mrs < MOD_PS / 1000.0) bad(2);
      if (n - n_mpr < 1 + MPRR_NCK) bad(7);
    end
    case (pins)
      PIN_MRS:
      begin
        if (n - n_mrs < MRD_NCK) bad(1);
        t_mrs = $realtime;
        n_mrs = n;
        if (ba == 3'h3 && !addr[2]) n_mpr = n;
      end
      PIN_ACT:
      begin
        if (n - n_act < RRD_NCK) bad(8);
        if ($realtime - t_act[0] < RRD_PS_SLOW / 1000.0) bad(8);
        if ($realtime - t_act[3] < FAW_PS_1600 / 1000.0) bad(9);
        if (n < ok_act[ba]) bad(6);
        t_act = '{$realtime, t_act[0], t_act[1], t_act[2]};
        n_act = n;
      end
      PIN_RD, PIN_WR:
      begin
        if (n - n_col < CCD_NCK) bad(3);
        n_col = n;
        if (pins == PIN_WR && addr[AP_BIT]) ok_act[ba] = n + DAL;
        if (pins == PIN_RD)
        begin
          if ($realtime - t_wend < WTR_PS / 1000.0) bad(5);
          t_rd[ba] = $realtime;
          burst(addr[7:0]);
        end
      end
      PIN_PRE:
        if ($realtime - t_rd[ba] < RTP_PS / 1000.0) bad(4);
      default: ;
    endcase
  end

  // write strobe framing and beat capture, sampled mid clk
  always @(negedge clk)
  begin
    if (!dqs_oe_n && !drv_q) t_on = $realtime;
    if (!dqs_oe_n && !drv_q) nb = 0;
    if (!dq_oe_n && dqs_o !== s_q && nb < BL_DEF)
    begin
      if (nb == 0 && $realtime - t_on < 0.9 * tck) bad(10);
      wr_seen[nb*8 +: 8] = dq_o;
      t_last = $realtime;
      nb = nb + 1;
      if (nb == BL_DEF) t_wend = t_last + tck / 2.0 - CLK_PS / 2000.0;
    end
    if (dqs_oe_n && drv_q && $realtime - t_last < 0.8 * tck) bad(10);
    drv_q = !dqs_oe_n;
    s_q = dqs_o;
  end
endmodule // ddrh_dev
`default_nettype wire

// [verif/tb.sv]
// testbench: drives the ddr3 host and judges it against a device model
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ddrh_pkg::*;
  localparam logic [63:0] WD = 64'hF0E1D2C3B4A59687;
  localparam int RD_MIN = CK_LAG + (RL_DEF + BL_DEF / 2) * CK_DIV;
  logic clk, rst_n, cmd_valid, cmd_ready, rd_valid, rd_err, rd_window;
  logic [2:0] cmd_op, cmd_ba, ddr_ba;
  logic [15:0] cmd_addr, ddr_addr;
  logic [63:0] cmd_wdata, rd_data, wr_seen;
  logic ddr_ck, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
  logic dqs_o, dqs_oe_n, dq_oe_n, dev_dqs, dev_oe;
  logic [7:0] dq_o, dev_dq;
  wire logic dqs_i;
  wire logic [7:0] dq_i;
  int fail_count = 0;
  int n_checks = 0;
  int viol;
  realtime t_take, t0, t1;
  realtime t_a[5];

  // strobe idles low through its pull-down when nobody drives it
  assign dqs_i = !dqs_oe_n ? dqs_o : dev_oe ? dev_dqs : 1'b0;
  assign dq_i = !dq_oe_n ? dq_o : dev_dq;

  ddrh_ctrl ddrh_ctrl_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_ba(cmd_ba),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
    .rd_err(rd_err), .rd_data(rd_data), .rd_window(rd_window),
    .ddr_ck(ddr_ck), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
    .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba),
    .ddr_addr(ddr_addr), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n),
    .dqs_i(dqs_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));

  ddrh_dev ddrh_dev_i (.clk(clk), .ddr_ck(ddr_ck),
    .pins({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n}), .ba(ddr_ba),
    .addr(ddr_addr), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n), .dq_o(dq_o),
    .dq_oe_n(dq_oe_n), .dev_dqs(dev_dqs), .dev_oe(dev_oe),
    .dev_dq(dev_dq), .wr_seen(wr_seen), .viol(viol));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----
  // checking and bus tasks
  // ----
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_min(input int got, input int lo);
    n_checks++;
    if (got < lo)
    begin
      fail_count++;
      $display("BAD at %0t: got %h below %h", $time, got, lo);
    end
  endtask

  function automatic int gap(input realtime a);
    return int'((t_take - a) / 20.0);
  endfunction

  // request held until the edge that takes it
  task automatic issue(input logic [2:0] op, input logic [2:0] ba,
                       input logic [15:0] ad, input logic [63:0] wd);
    int k = 0;
    @(posedge clk);
    cmd_op <= op;
    cmd_ba <= ba;
    cmd_addr <= ad;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (cmd_ready !== 1'b1 && k < 500);
    if (cmd_ready !== 1'b1) fail_count++;
    @(posedge clk);
    t_take = $realtime;
    cmd_valid <= 1'b0;
  endtask

  task automatic rd_wait(input realtime ts, input logic [7:0] col);
    int k = 0;
    logic [63:0] e;
    for (int i = 0; i < 8; i++) e[i*8 +: 8] = col + 8'(i * 17);
    do
    begin
      @(negedge clk);
      k++;
    end
    while (rd_valid !== 1'b1 && k < 200);
    if (rd_valid !== 1'b1) fail_count++;
    check_val(rd_window, 1'b0);
    k = int'(($realtime - ts - 10.0) / 20.0);
    check_min(k, RD_MIN);
    check_min(RD_MIN + SYNC_STAGES + 1, k);
    check_val(rd_data, e);
    check_val(rd_err, 1'b0);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    @(negedge clk);
    check_val({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n}, PIN_DES);
    check_val({dqs_oe_n, dq_oe_n, cmd_ready}, 3'h6);
  endtask

  task automatic t_mode;
    issue(OP_MRS, 3'h0, 16'h0000, 64'h0);
    t0 = t_take;
    issue(OP_MRS, 3'h2, 16'h0000, 64'h0);
    check_min(gap(t0), MRD_NCK * CK_DIV);
    issue(OP_MPR, 3'h3, 16'h0000, 64'h0);
    t0 = t_take;
    issue(OP_PRE, 3'h7, 16'h0000, 64'h0);
    check_min(gap(t0), (1 + MPRR_NCK) * CK_DIV);
  endtask

  task automatic t_acts;
    for (int b = 0; b < 5; b++)
    begin
      issue(OP_ACT, 3'(b), 16'h0100, 64'h0);
      t_a[b] = t_take;
      if (b > 0) check_min(gap(t_a[b-1]), RRD_NCK * CK_DIV);
    end
    check_min(gap(t_a[0]), (FAW_PS_1600 + CLK_PS - 1) / CLK_PS);
  endtask

  task automatic t_wr_rd;
    issue(OP_WR, 3'h1, 16'h0008, WD);
    t0 = t_take;
    issue(OP_RD, 3'h1, 16'h0010, 64'h0);
    check_min(gap(t0), CK_LAG + (WL_DEF + BL_DEF / 2) * CK_DIV
      + (WTR_PS + CLK_PS - 1) / CLK_PS);
    t0 = t_take;
    issue(OP_PRE, 3'h1, 16'h0000, 64'h0);
    check_min(gap(t0), (RTP_PS + CLK_PS - 1) / CLK_PS);
    rd_wait(t0, 8'h10);
    check_val(wr_seen, WD);
  endtask

  // second read requested while the first burst is still out
  task automatic t_rd_rd;
    issue(OP_RD, 3'h3, 16'h0020, 64'h0);
    t0 = t_take;
    fork
      rd_wait(t0, 8'h20);
      begin
        issue(OP_RD, 3'h3, 16'h0030, 64'h0);
        t1 = t_take;
        check_min(gap(t0), CCD_NCK * CK_DIV);
      end
    join
    rd_wait(t1, 8'h30);
  endtask

  task automatic t_wra;
    issue(OP_WR, 3'h2, 16'h0400, ~WD);
    t0 = t_take;
    issue(OP_ACT, 3'h2, 16'h0200, 64'h0);
    check_min(gap(t0), (WL_DEF + BL_DEF / 2 + WR_NCK_DEF
      + (RP_PS_DEF + CK_PS - 1) / CK_PS) * CK_DIV);
    check_val(wr_seen, ~WD);
  endtask

  initial
  begin
    #100000;
    fail_count++;
    final_report();
  end

  initial
  begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_ba = 3'h0;
    cmd_addr = 16'h0000;
    cmd_wdata = 64'h0;
    repeat (7) @(posedge clk);
    t_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    t_mode();
    t_acts();
    t_wr_rd();
    t_rd_rd();
    t_wra();
    repeat (60) @(posedge clk);
    check_val(64'(viol), 64'h0);
    final_report();
  end
endmodule // tb
`default_nettype wire
